// ### src/ilg_ilas_param_gen.sv
// lane alignment configuration generator with apb register file
`timescale 1ns/1ps
module ilg_ilas_param_gen (
  input  wire logic             i_ref_clk,      // 50 MHz clock
  input  wire logic             i_rst,          // async reset, active high
  input  wire logic             psel,           // apb select
  input  wire logic             penable,        // apb access phase
  input  wire logic             pwrite,         // apb direction
  input  wire logic [7:0]       paddr,          // apb byte address
  input  wire logic [31:0]      pwdata,         // apb write data
  output logic      [31:0]      prdata,         // apb read data
  output logic                  pready,         // apb ready
  output logic                  pslverr,        // apb error
  input  wire logic             i_ilas_req,     // start octet stream, one cycle
  input  wire logic [3:0]       i_ilas_lane,    // lane: bit3 link, [2:0] lane id
  output ilg_pkg::ilg_octet_t   o_octet,        // configuration octet stream
  output logic                  o_busy,         // stream in progress
  output logic                  o_req_refused   // request refused, one cycle
);
  import ilg_pkg::*;

  typedef struct packed {
    logic [4:0]  mode;
    logic [4:0]  kset;
    logic [7:0]  did;
    logic        scr;
    logic [3:0]  lane_sel;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        busy;
    logic [3:0]  cnt;
    logic [3:0]  lane;
    ilg_cfg_t    sh;
    ilg_octet_t  oct;
    logic        refused;
  } ilg_state_t;

  ilg_state_t s;
  ilg_state_t next_s;
  ilg_mode_t  cur;
  logic [5:0] kval;
  logic       k_ok;
  logic       cfg_ok;
  logic       req_ok;
  logic       accept;
  ilg_cfg_t   req_cfg;
  ilg_cfg_t   sel_cfg;
  logic       mapped;
  logic       apb_take;
  logic       apb_wdone;

  //==============================================================
  // derived values
  function automatic logic lane_ok(input ilg_mode_t md, input logic [3:0] ln);
    return ({1'b0, ln[2:0]} < md.l) && (!ln[3] || md.links == 2'h2);
  endfunction

  // octet build for one lane, checksum last
  function automatic ilg_cfg_t build(input ilg_mode_t md, input logic [3:0] ln,
                                     input logic [7:0] did, input logic [4:0] kset,
                                     input logic scr);
    ilg_cfg_t c;
    logic [7:0] sum;
    c = '0;
    c[0]  = did;
    c[1]  = 8'h00;
    c[2]  = {3'h0, 2'h0, ln[2:0]};
    c[3]  = {scr, 2'h0, 1'b0, md.l - 4'h1};
    c[4]  = {4'h0, md.f - 4'h1};
    c[5]  = {3'h0, kset};
    c[6]  = {4'h0, md.m - 4'h1};
    c[7]  = {2'h0, 1'b0, md.n - 5'h01};
    c[8]  = {SUBCLASS_VER, md.np - 5'h01};
    c[9]  = {JESD_REV, 1'b0, md.s - 4'h1};
    c[10] = 8'h00;
    c[11] = 8'h00;
    c[12] = 8'h00;
    // field values summed, not whole octets
    sum = did + {5'h00, ln[2:0]} + {7'h00, scr} + {4'h0, md.l - 4'h1}
        + {4'h0, md.f - 4'h1} + {3'h0, kset} + {4'h0, md.m - 4'h1}
        + {3'h0, md.n - 5'h01} + {5'h00, SUBCLASS_VER} + {3'h0, md.np - 5'h01}
        + {5'h00, JESD_REV} + {4'h0, md.s - 4'h1};
    c[13] = sum;
    return c;
  endfunction

  always_comb begin
    cur     = ilg_mode_lut(s.mode);
    kval    = {1'b0, s.kset} + 6'h01;
    k_ok    = (kval >= cur.kmin) && (kval <= K_MAX)
            && (cur.kstep == 2'h1 || !(kval[0] ^ cur.kmin[0]));
    cfg_ok  = cur.valid && k_ok;
    req_ok  = cfg_ok && lane_ok(cur, i_ilas_lane);
    // a write landing after the start would change config inside the stream
    accept  = i_ilas_req && req_ok && !s.busy && !(psel && penable && pwrite);
    req_cfg = build(cur, i_ilas_lane, s.did, s.kset, s.scr);
    sel_cfg = build(cur, s.lane_sel, s.did, s.kset, s.scr);
    mapped  = (paddr == ADDR_MODE) || (paddr == ADDR_KSET) || (paddr == ADDR_DID)
           || (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_LANE_SEL);
    apb_take  = psel && penable && !s.pready;
    apb_wdone = psel && penable && s.pready && pwrite && !s.pslverr;
  end

  //==============================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.refused = i_ilas_req && !accept;
    // apb: access phase held one cycle, answered on the next
    if (psel && penable && !s.pready) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !mapped
                    || (pwrite && s.busy && paddr != ADDR_LANE_SEL)
                    || (pwrite && paddr == ADDR_STATUS);
      next_s.prdata  = 32'h0;
      if (!pwrite) begin
        case (paddr)
          ADDR_MODE:     next_s.prdata = {27'h0, s.mode};
          ADDR_KSET:     next_s.prdata = {27'h0, s.kset};
          ADDR_DID:      next_s.prdata = {24'h0, s.did};
          ADDR_CTRL:     next_s.prdata = {31'h0, s.scr};
          ADDR_LANE_SEL: next_s.prdata = {28'h0, s.lane_sel};
          ADDR_STATUS: begin
            next_s.prdata[STAT_MODE_OK]             = cur.valid;
            next_s.prdata[STAT_K_OK]                = k_ok;
            next_s.prdata[STAT_LANE_OK]             = lane_ok(cur, s.lane_sel);
            next_s.prdata[STAT_BUSY]                = s.busy;
            next_s.prdata[STAT_CHK_LSB +: 8]        = sel_cfg[13];
          end
          default:       next_s.prdata = 32'h0;
        endcase
      end
    end else if (psel && penable && s.pready) begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      // write lands on the completing edge; config frozen during a stream
      if (pwrite && !s.pslverr) begin
        case (paddr)
          ADDR_MODE:     next_s.mode     = pwdata[4:0];
          ADDR_KSET:     next_s.kset     = pwdata[4:0];
          ADDR_DID:      next_s.did      = pwdata[7:0];
          ADDR_CTRL:     next_s.scr      = pwdata[CTRL_SCR_BIT];
          ADDR_LANE_SEL: next_s.lane_sel = pwdata[3:0];
          default:       next_s.mode     = s.mode;
        endcase
      end
    end else begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
    end
    // octet stream
    if (accept) begin
      next_s.busy      = 1'b1;
      next_s.cnt       = 4'h0;
      next_s.lane      = i_ilas_lane;
      next_s.sh        = req_cfg;
      next_s.oct.valid = 1'b1;
      next_s.oct.last  = 1'b0;
      next_s.oct.data  = req_cfg[0];
    end else if (s.busy) begin
      if (s.cnt == LAST_OCTET) begin
        next_s.busy = 1'b0;
        next_s.oct  = '0;
      end else begin
        next_s.cnt       = s.cnt + 4'h1;
        next_s.oct.valid = 1'b1;
        next_s.oct.last  = (s.cnt + 4'h1) == LAST_OCTET;
        next_s.oct.data  = s.sh[s.cnt + 4'h1];
      end
    end
  end

  //==============================================================
  // state register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s          <= '0;
      s.mode     <= RST_MODE;
      s.kset     <= RST_KSET;
      s.did      <= RST_DID;
    end else begin
      s <= next_s;
    end
  end

  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign o_octet       = s.oct;
  assign o_busy        = s.busy;
  assign o_req_refused = s.refused;

  //==============================================================
  // assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_stream_len: assert property (accept |-> ##14 (s.oct.valid && s.oct.last) ##1 !s.busy)
    else $error("octet stream length wrong");
  a_adj_zero: assert property (s.oct.valid && s.cnt == 4'h1 |-> s.oct.data == 8'h00)
    else $error("adjust or bank field not zero");
  a_resv_zero: assert property (s.oct.valid && (s.cnt == 4'hb || s.cnt == 4'hc)
                                |-> s.oct.data == 8'h00)
    else $error("reserved field not zero");
  a_hd_zero: assert property (s.oct.valid && s.cnt == 4'ha |-> s.oct.data == 8'h00)
    else $error("high density or cf not zero");
  a_cs_zero: assert property (s.oct.valid && s.cnt == 4'h7 |-> s.oct.data[7:6] == 2'h0)
    else $error("control bits field not zero");
  a_did_field: assert property (s.oct.valid && s.cnt == 4'h0 |-> s.oct.data == s.did)
    else $error("device id octet mismatch");
  a_k_field: assert property (s.oct.valid && s.cnt == 4'h5
                              |-> s.oct.data == {3'h0, s.kset})
    else $error("k octet mismatch");
  a_k_range: assert property (accept |-> kval >= cur.kmin && kval <= K_MAX)
    else $error("stream started with k out of range");
  a_scr_field: assert property (s.oct.valid && s.cnt == 4'h3 |-> s.oct.data[7] == s.scr)
    else $error("scrambler bit mismatch");
  a_f_field: assert property (s.oct.valid && s.cnt == 4'h4
                              |-> s.oct.data == {4'h0, cur.f - 4'h1})
    else $error("octets per frame mismatch");
  a_np_field: assert property (s.oct.valid && s.cnt == 4'h8
                               |-> s.oct.data[4:0] == cur.np - 5'h01)
    else $error("bits per sample mismatch");
  a_lid_field: assert property (s.oct.valid && s.cnt == 4'h2
                                |-> s.oct.data == {5'h00, s.lane[2:0]})
    else $error("lane id mismatch");
  a_version: assert property (s.oct.valid && (s.cnt == 4'h8 || s.cnt == 4'h9)
                              |-> s.oct.data[7:5] == 3'h1)
    else $error("version field not one");
  a_bad_mode: assert property (i_ilas_req && !cur.valid |=> s.refused && !$rose(s.busy))
    else $error("invalid mode not refused");
  a_apb_answer: assert property (psel && penable && !s.pready |=> s.pready ##1 !s.pready)
    else $error("apb answer timing wrong");

  //==============================================================
  // stream framing assertions
  a_start_run: assert property (accept |=> s.busy && s.oct.valid && s.cnt == 4'h0)
    else $error("stream did not start");

  a_busy_valid: assert property (s.busy |-> s.oct.valid)
    else $error("busy without valid octet");

  a_idle_quiet: assert property (!s.busy |-> !s.oct.valid && !s.oct.last)
    else $error("octet valid while idle");

  a_last_pos: assert property (s.oct.last |-> s.oct.valid && s.cnt == LAST_OCTET)
    else $error("last flag on wrong octet");

  a_cnt_step: assert property (s.busy && s.cnt != LAST_OCTET
                               |=> s.cnt == $past(s.cnt) + 4'h1)
    else $error("octet counter skipped");

  a_lane_held: assert property (s.busy |=> $stable(s.lane))
    else $error("lane changed inside a stream");

  //==============================================================
  // derived field assertions
  a_l_field: assert property (s.oct.valid && s.cnt == 4'h3
                              |-> s.oct.data[4:0] == {1'b0, cur.l - 4'h1})
    else $error("lanes per link mismatch");

  a_m_field: assert property (s.oct.valid && s.cnt == 4'h6
                              |-> s.oct.data == {4'h0, cur.m - 4'h1})
    else $error("converters mismatch");

  a_n_field: assert property (s.oct.valid && s.cnt == 4'h7
                              |-> s.oct.data[4:0] == cur.n - 5'h01)
    else $error("resolution mismatch");

  a_s_field: assert property (s.oct.valid && s.cnt == 4'h9
                              |-> s.oct.data[4:0] == {1'b0, cur.s - 4'h1})
    else $error("samples per frame mismatch");

  a_chk_sum: assert property (s.oct.valid && s.cnt == LAST_OCTET
                              |-> s.oct.data == 8'(s.sh[0] + s.sh[2][4:0] + s.sh[3][7]
                              + s.sh[3][4:0] + s.sh[4] + s.sh[5] + s.sh[6] + s.sh[7][4:0]
                              + s.sh[8][7:5] + s.sh[8][4:0] + s.sh[9][7:5] + s.sh[9][4:0]))
    else $error("checksum octet mismatch");

  //==============================================================
  // request handling assertions
  a_k_refuse: assert property (i_ilas_req && !k_ok |=> s.refused && !$rose(s.busy))
    else $error("illegal k not refused");

  a_lane_refuse: assert property (i_ilas_req && !lane_ok(cur, i_ilas_lane)
                                  |=> s.refused)
    else $error("absent lane not refused");

  a_mode_list: assert property (accept |-> s.mode <= 5'h12 && s.mode != 5'h08)
    else $error("stream started in unlisted mode");

  a_busy_refuse: assert property (i_ilas_req && s.busy |=> s.refused)
    else $error("request while busy not refused");

  a_no_refuse: assert property (!i_ilas_req |=> !s.refused)
    else $error("refusal without request");

  a_cfg_frozen: assert property (s.busy |=> $stable(s.mode) && $stable(s.kset)
                                 && $stable(s.did) && $stable(s.scr))
    else $error("config changed inside a stream");

  //==============================================================
  // register access assertions
  a_wr_mode: assert property (apb_wdone && paddr == ADDR_MODE
                              |=> s.mode == $past(pwdata[4:0]))
    else $error("mode write lost");

  a_wr_kset: assert property (apb_wdone && paddr == ADDR_KSET
                              |=> s.kset == $past(pwdata[4:0]))
    else $error("k setting write lost");

  a_wr_did: assert property (apb_wdone && paddr == ADDR_DID
                             |=> s.did == $past(pwdata[7:0]))
    else $error("identifier write lost");

  a_wr_scr: assert property (apb_wdone && paddr == ADDR_CTRL
                             |=> s.scr == $past(pwdata[CTRL_SCR_BIT]))
    else $error("scrambler write lost");

  a_rd_kset: assert property (apb_take && !pwrite && paddr == ADDR_KSET
                              |=> s.prdata == {27'h0, s.kset})
    else $error("k setting readback wrong");

  a_err_busy: assert property (apb_take && pwrite && s.busy && paddr != ADDR_LANE_SEL
                               |=> s.pslverr)
    else $error("write while busy not refused");

  a_err_status: assert property (apb_take && pwrite && paddr == ADDR_STATUS
                                 |=> s.pslverr)
    else $error("status write not refused");

  a_err_unmap: assert property (apb_take && !mapped
                                |=> s.pslverr && s.prdata == 32'h0)
    else $error("unmapped access not refused");

  a_err_quiet: assert property (!s.pready |-> !s.pslverr)
    else $error("error without ready");

  c_stream_done: cover property (accept ##14 s.oct.last);
  c_refused: cover property (i_ilas_req && !cur.valid ##1 s.refused);
  c_write_busy: cover property (psel && penable && pwrite && s.busy ##1 s.pslverr);
  c_mode_wide: cover property (accept && s.mode == 5'h0f);
  c_status_rd: cover property (apb_take && !pwrite && paddr == ADDR_STATUS);
endmodule // ilg_ilas_param_gen

// ### src/ilg_pkg.sv
// constants, types and mode table of the lane alignment parameter generator
//==============================================================
// Summary of operation
// - every link parameter goes out on each lane in alignment configuration octets
// - most parameters follow the mode; id, frames per multiframe, scrambler from user
// - multiframe clock adjust amount and direction always sent as zero
// - bank id, control words per frame and both reserved fields sent as zero
// - high density flag always zero, samples never split across lanes
// - control bits per sample sent as zero even when control bits are used
// - device identifier comes straight from the user identifier register
// - frames per multiframe comes from a user register and is reported
// - multiframe length must respect the mode's minimum and step and the fixed maximum K_MAX
// - scrambler enable comes from a control register bit and is reported
// - octets per frame, lanes, converters, resolution, samples follow the mode
// - bits per sample incl. control and tail bits follow the mode separately
// - each lane carries its own derived lane identifier
// - checksum is the sum of all preceding parameters modulo 256
// - only listed mode encodings are valid; others are refused
package ilg_pkg;
  //==============================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_MODE     = 8'h00;
  localparam logic [7:0] ADDR_KSET     = 8'h04;
  localparam logic [7:0] ADDR_DID      = 8'h08;
  localparam logic [7:0] ADDR_CTRL     = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_LANE_SEL = 8'h14;
  //==============================================================
  // field positions and reset values
  localparam int         CTRL_SCR_BIT   = 0;
  localparam int         STAT_MODE_OK   = 0;
  localparam int         STAT_K_OK      = 1;
  localparam int         STAT_LANE_OK   = 2;
  localparam int         STAT_BUSY      = 3;
  localparam int         STAT_CHK_LSB   = 8;
  localparam logic [4:0] RST_MODE       = 5'h00;
  localparam logic [4:0] RST_KSET       = 5'h1f;
  localparam logic [7:0] RST_DID        = 8'h00;
  //==============================================================
  // fixed link values and stream length
  localparam logic [2:0] JESD_REV       = 3'h1;
  localparam logic [2:0] SUBCLASS_VER   = 3'h1;
  localparam logic [5:0] K_MAX          = 6'h20;
  localparam int         ILAS_OCTETS    = 14;
  localparam logic [3:0] LAST_OCTET     = 4'hd;

  typedef struct packed {
    logic       valid;
    logic [5:0] kmin;
    logic [1:0] kstep;
    logic [1:0] links;
    logic [3:0] l;   // lanes per link
    logic [3:0] m;   // converters per link
    logic [3:0] f;   // octets per frame
    logic [3:0] s;   // samples per converter per frame
    logic [4:0] n;   // resolution
    logic [4:0] np;  // bits per sample incl. control and tail
  } ilg_mode_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } ilg_octet_t;

  typedef logic [ILAS_OCTETS-1:0][7:0] ilg_cfg_t;

  // per-mode derived values; unlisted codes come back invalid
  function automatic ilg_mode_t ilg_mode_lut(input logic [4:0] sel);
    ilg_mode_t r;
    r = '0;
    case (sel)
      5'h00, 5'h02: r = '{1'b1, 6'h03, 2'h1, 2'h2, 4'h4, 4'h4, 4'h8, 4'h5, 5'h0c, 5'h0c};
      5'h01, 5'h03,
      5'h0c:        r = '{1'b1, 6'h03, 2'h1, 2'h2, 4'h8, 4'h8, 4'h8, 4'h5, 5'h0c, 5'h0c};
      5'h04, 5'h06: r = '{1'b1, 6'h12, 2'h2, 2'h2, 4'h2, 4'h1, 4'h1, 4'h2, 5'h08, 5'h08};
      5'h05, 5'h07: r = '{1'b1, 6'h12, 2'h2, 2'h2, 4'h4, 4'h1, 4'h1, 4'h4, 5'h08, 5'h08};
      5'h09:        r = '{1'b1, 6'h09, 2'h1, 2'h2, 4'h4, 4'h1, 4'h2, 4'h4, 5'h0f, 5'h10};
      5'h0a, 5'h0e: r = '{1'b1, 6'h09, 2'h1, 2'h2, 4'h2, 4'h2, 4'h2, 4'h1, 5'h0f, 5'h10};
      5'h0b:        r = '{1'b1, 6'h09, 2'h1, 2'h2, 4'h4, 4'h2, 4'h2, 4'h2, 5'h0f, 5'h10};
      5'h0d, 5'h10: r = '{1'b1, 6'h05, 2'h1, 2'h2, 4'h1, 4'h2, 4'h4, 4'h1, 5'h0f, 5'h10};
      5'h0f:        r = '{1'b1, 6'h03, 2'h1, 2'h1, 4'h1, 4'h4, 4'h8, 4'h1, 5'h0f, 5'h10};
      5'h11, 5'h12: r = '{1'b1, 6'h12, 2'h2, 2'h2, 4'h8, 4'h1, 4'h1, 4'h8, 5'h08, 5'h08};
      default:      r = '0;
    endcase
    return r;
  endfunction
endpackage

// ### sim/ilg_rx_model.sv
// receiver-side model that collects configuration octets and verifies the checksum
`timescale 1ns/1ps
module ilg_rx_model (
  input  wire logic                i_ref_clk,  // device clock
  input  wire ilg_pkg::ilg_octet_t i_octet,    // octet stream from the generator
  output ilg_pkg::ilg_cfg_t        o_cfg,      // octets of the last stream
  output int                       o_frames,   // completed streams
  output logic                     o_chk_ok    // last stream framed and checksum matched
);
  import ilg_pkg::*;
  int idx;

  // field sum as a receiver recomputes it
  function automatic logic [7:0] sum_fields(input ilg_cfg_t c);
    return c[0] + c[2][4:0] + c[3][7] + c[3][4:0] + c[4] + c[5][4:0] + c[6] + c[7][4:0]
         + c[8][7:5] + c[8][4:0] + c[9][7:5] + c[9][4:0];
  endfunction

  initial begin
    idx = 0;
    o_frames = 0;
    o_chk_ok = 1'b0;
    o_cfg = '0;
  end

  always @(posedge i_ref_clk) begin
    if (i_octet.valid) begin
      if (idx < ILAS_OCTETS) begin
        o_cfg[idx] = i_octet.data;
      end
      idx = idx + 1;
      if (i_octet.last) begin
        o_chk_ok = (idx == ILAS_OCTETS) && (i_octet.data === sum_fields(o_cfg));
        o_frames = o_frames + 1;
        idx = 0;
      end
    end
  end
endmodule  // ilg_rx_model

// ### sim/ilg_ilas_param_gen_tb_top.sv
// self-checking bench for the lane alignment parameter generator
`timescale 1ns/1ps
module ilg_ilas_param_gen_tb_top;
  import ilg_pkg::*;
  logic        i_ref_clk   = 1'b0;
  logic        i_rst       = 1'b1;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0;
  logic        i_ilas_req  = 1'b0;
  logic [3:0]  i_ilas_lane = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  ilg_octet_t  o_octet;
  logic        o_busy;
  logic        o_req_refused;
  ilg_cfg_t    rx_cfg;
  int          rx_frames;
  logic        rx_chk_ok;
  int          n_fail      = 0;
  int          n_compared  = 0;
  logic [31:0] rd;
  logic        er;

  always #10 i_ref_clk = ~i_ref_clk;

  ilg_ilas_param_gen DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_ilas_req(i_ilas_req), .i_ilas_lane(i_ilas_lane), .o_octet(o_octet),
    .o_busy(o_busy), .o_req_refused(o_req_refused));
  ilg_rx_model u_rx (.i_ref_clk(i_ref_clk), .i_octet(o_octet), .o_cfg(rx_cfg),
    .o_frames(rx_frames), .o_chk_ok(rx_chk_ok));

  //==============================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(er, 1'b0, "config write");
  endtask

  task automatic pulse(input logic [3:0] lane);
    @(posedge i_ref_clk);
    i_ilas_req  <= 1'b1;
    i_ilas_lane <= lane;
    @(posedge i_ref_clk);
    i_ilas_req  <= 1'b0;
  endtask

  task automatic wait_frame(input int fr);
    int t;
    t = 0;
    while (rx_frames == fr && t < 40) begin
      @(posedge i_ref_clk);
      t++;
    end
    chk(rx_frames, fr + 1, "stream completed");
  endtask

  // configure, request one lane, judge refusal or the whole octet stream
  task automatic run(input logic [4:0] md, input logic [4:0] ks, input logic [7:0] did,
                     input logic scr, input logic [3:0] ln, input logic ok,
                     input int l, input int m, input int f, input int s, input int n,
                     input int np);
    logic [7:0] e [14];
    int         fr;
    e = '{default: 8'h00};
    wr(ADDR_MODE, {27'h0, md});
    wr(ADDR_KSET, {27'h0, ks});
    wr(ADDR_DID, {24'h0, did});
    wr(ADDR_CTRL, {31'h0, scr});
    fr = rx_frames;
    pulse(ln);
    @(posedge i_ref_clk);
    chk(o_req_refused, !ok, "request refusal");
    chk(o_busy, ok, "busy after request");
    if (ok) begin
      wait_frame(fr);
      e[0] = did;
      e[2] = {5'h0, ln[2:0]};
      e[3] = {scr, 2'h0, 5'(l - 1)};
      e[4] = 8'(f - 1);
      e[5] = {3'h0, ks};
      e[6] = 8'(m - 1);
      e[7] = {3'h0, 5'(n - 1)};
      e[8] = {3'h1, 5'(np - 1)};
      e[9] = {3'h1, 5'(s - 1)};
      e[13] = 8'(did + ln[2:0] + scr + l - 1 + f - 1 + ks + m - 1 + n - 1 + np - 1 + s + 1);
      for (int i = 0; i < 14; i++) begin
        chk(rx_cfg[i], e[i], "octet");
      end
      chk(rx_chk_ok, 1'b1, "receiver check");
    end
  endtask

  //==============================================================
  // scenarios
  task automatic t_reset;
    apb(1'b0, ADDR_MODE, 32'h0);
    chk(rd, {27'h0, RST_MODE}, "mode reset");
    apb(1'b0, ADDR_KSET, 32'h0);
    chk(rd, {27'h0, RST_KSET}, "kset reset");
    apb(1'b0, ADDR_DID, 32'h0);
    chk(rd, {24'h0, RST_DID}, "did reset");
    apb(1'b0, 8'h18, 32'h0);
    chk({rd[30:0], er}, 32'h1, "unmapped read");
    apb(1'b1, ADDR_STATUS, 32'hff);
    chk(er, 1'b1, "status write");
    $display("test reset done");
  endtask

  task automatic t_modes;
    run(5'd0, 5'h1f, 8'h5a, 1'b1, 4'h3, 1'b1, 4, 4, 8, 5, 12, 12);
    run(5'd9, 5'h08, 8'ha5, 1'b0, 4'hb, 1'b1, 4, 1, 2, 4, 15, 16);
    run(5'd15, 5'h02, 8'hff, 1'b1, 4'h0, 1'b1, 1, 4, 8, 1, 15, 16);
    run(5'd18, 5'h11, 8'h01, 1'b0, 4'hf, 1'b1, 8, 1, 1, 8, 8, 8);
    run(5'd13, 5'h04, 8'h10, 1'b1, 4'h8, 1'b1, 1, 2, 4, 1, 15, 16);
    // refused: reserved mode, off-step K, K below minimum, absent link, lane beyond L
    run(5'd8, 5'h1f, 8'h00, 1'b0, 4'h0, 1'b0, 0, 0, 0, 0, 0, 0);
    run(5'd4, 5'h12, 8'h00, 1'b0, 4'h0, 1'b0, 0, 0, 0, 0, 0, 0);
    run(5'd4, 5'h10, 8'h00, 1'b0, 4'h0, 1'b0, 0, 0, 0, 0, 0, 0);
    run(5'd15, 5'h1f, 8'h00, 1'b0, 4'h8, 1'b0, 0, 0, 0, 0, 0, 0);
    run(5'd0, 5'h1f, 8'h00, 1'b0, 4'h4, 1'b0, 0, 0, 0, 0, 0, 0);
    $display("test modes done");
  endtask

  task automatic t_busy;
    int fr;
    wr(ADDR_MODE, 32'h2);
    wr(ADDR_KSET, 32'h1f);
    wr(ADDR_DID, 32'h3c);
    fr = rx_frames;
    pulse(4'h1);
    pulse(4'h2);
    @(posedge i_ref_clk);
    chk(o_req_refused, 1'b1, "request while busy");
    apb(1'b1, ADDR_DID, 32'h77);
    chk(er, 1'b1, "write while busy");
    wait_frame(fr);
    chk(rx_cfg[0], 8'h3c, "did held while busy");
    chk(rx_cfg[2], 8'h01, "lane of first request");
    $display("test busy done");
  endtask

  // lane select and status word after the busy test: mode 2, K 32, id 3c, scrambler off
  task automatic t_status;
    logic [31:0] st;
    st = (32'h1 << STAT_MODE_OK) | (32'h1 << STAT_K_OK);
    wr(ADDR_LANE_SEL, 32'h9);
    apb(1'b0, ADDR_LANE_SEL, 32'h0);
    chk(rd, 32'h9, "lane select readback");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, st | (32'h1 << STAT_LANE_OK) | (32'h85 << STAT_CHK_LSB), "status lid 1");
    wr(ADDR_LANE_SEL, 32'h4);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, st | (32'h88 << STAT_CHK_LSB), "status lane beyond L");
    $display("test status done");
  endtask

  task automatic final_report;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_reset;
    t_modes;
    t_busy;
    t_status;
    final_report;
  end

  // tests need well under 1000 cycles; 10000 cycles means a hang
  initial begin
    #200000;
    n_fail++;
    final_report;
  end
endmodule  // ilg_ilas_param_gen_tb_top
